// >>> vxec_consts.svh
// Purpose: Offsets, field positions, reset values and counts for vxec.
// Assumes: Byte addresses on a 32-bit register port, one word each.
// Notes: Definitions only; included by bare name.
`ifndef VXEC_CONSTS_SVH
`define VXEC_CONSTS_SVH

// Register byte offsets.
`define VXEC_OFF_TAG 8'h00
`define VXEC_OFF_GAP 8'h04
`define VXEC_OFF_WIN 8'h08
`define VXEC_OFF_FUNC_LO 8'h0C
`define VXEC_OFF_FUNC_HI 8'h10
`define VXEC_OFF_LIST_LO 8'h14
`define VXEC_OFF_LIST_HI 8'h18
`define VXEC_OFF_EXIT 8'h1C
`define VXEC_OFF_STATUS 8'h20
`define VXEC_OFF_INFO 8'h24

// Field positions.
`define VXEC_FUNC_SWITCH_BIT 0
`define VXEC_EXIT_SAVE_DBG 2
`define VXEC_EXIT_HOST_LONG 9
`define VXEC_EXIT_LOAD_PERF 12
`define VXEC_EXIT_ACK_INTR 15
`define VXEC_EXIT_SAVE_PAT 18
`define VXEC_EXIT_LOAD_PAT 19
`define VXEC_EXIT_SAVE_EFER 20
`define VXEC_EXIT_LOAD_EFER 21
`define VXEC_EXIT_SAVE_TMR 22
`define VXEC_STAT_ENTRY_OK 0
`define VXEC_STAT_ENTRY_FAIL 1
`define VXEC_STAT_FUNC_RSVD 2
`define VXEC_STAT_EXIT_BUSY 3
`define VXEC_STAT_PAUSE_EXIT 4
`define VXEC_INFO_VALID 31

// Reserved exit-control bits: forced to one and forced to zero.
`define VXEC_EXIT_MUST1 32'h0003_6DFF
`define VXEC_EXIT_MUST0 32'hFF80_0000

// Reset values.
`define VXEC_RST_WORD 32'h0000_0000
`define VXEC_RST_TAG 16'h0000

// Pointer list: entry size in bytes as a shift.
`define VXEC_LIST_ENTRY_SHIFT 3
`define VXEC_LIST_ENTRIES 512

// Core cycles per timestamp-counter tick.
`define VXEC_TSC_DIV 8

`endif

// >>> vxec_pkg.sv
// Purpose: Types shared by the vxec block.
// Assumes: Constants live in vxec_consts.svh.
// Notes: None.
package vxec_pkg;

  // Exit sequencing states.
  typedef enum logic [1:0] {
    VXEC_IDLE = 2'b00,
    VXEC_ACK_WAIT = 2'b01,
    VXEC_FINISH = 2'b10
  } vxec_exit_state_type;

endpackage

// >>> vxec_pause_timer.sv
// Purpose: Pause-loop detector timed in timestamp-counter ticks.
// Assumes: tick is a one-cycle enable at the timestamp-counter rate.
// Notes: Counters saturate so a long idle never wraps into a loop.
`timescale 1ns/1ps
`default_nettype none
module vxec_pause_timer #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic tick,
  input wire logic pause_seen,
  input wire logic [W-1:0] gap_limit,
  input wire logic [W-1:0] window_limit,
  output logic loop_exit_q
);

  // Ticks since the previous pause.
  logic [W-1:0] gap_cnt_q;
  // Ticks since the current loop began.
  logic [W-1:0] win_cnt_q;
  // A loop is being tracked.
  logic in_loop_q;
  // The pause continues the running loop.
  logic same_loop;
  assign same_loop = in_loop_q && (gap_cnt_q <= gap_limit);

  // Gap and window counters advance only on the timestamp tick.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_q <= '0;
      win_cnt_q <= '0;
    end else if (!enable) begin
      gap_cnt_q <= '0;
      win_cnt_q <= '0;
    end else if (pause_seen) begin
      gap_cnt_q <= '0;
      // A fresh loop restarts the window count.
      if (!same_loop) begin
        win_cnt_q <= '0;
      end
    end else if (tick) begin
      if (gap_cnt_q != '1) begin
        gap_cnt_q <= gap_cnt_q + 1'b1;
      end
      if (in_loop_q && win_cnt_q != '1) begin
        win_cnt_q <= win_cnt_q + 1'b1;
      end
    end
  end

  // Loop tracking and the exit pulse when the window is overrun.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_loop_q <= 1'b0;
      loop_exit_q <= 1'b0;
    end else begin
      loop_exit_q <= 1'b0;
      if (!enable) begin
        in_loop_q <= 1'b0;
      end else if (pause_seen) begin
        if (same_loop && win_cnt_q > window_limit) begin
          loop_exit_q <= 1'b1;
          in_loop_q <= 1'b0;
        end else begin
          in_loop_q <= 1'b1;
        end
      end
    end
  end

endmodule // vxec_pause_timer
`default_nettype wire

// >>> vxec_top.sv
// Purpose: Execution and exit control fields with their exit behaviour.
// Assumes: All request inputs come from logic on the same clock.
// Notes: Fields not supported by the build read zero and ignore writes, except exit-word bits, kept as written, and a set switch bit, counted as reserved.
`timescale 1ns/1ps
`default_nettype none
`include "vxec_consts.svh"
module vxec_top
  import vxec_pkg::*;
#(
  parameter bit HAS_TAG = 1'b1,
  parameter bit HAS_PAUSE = 1'b1,
  parameter bit HAS_FUNC = 1'b1,
  parameter bit HAS_SWITCH = 1'b1,
  parameter bit HAS_LONG = 1'b1,
  parameter bit MINIMAL = 1'b0,
  parameter int TSC_DIV = `VXEC_TSC_DIV
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pause_exec,
  input wire logic pause_enable,
  input wire logic entry_req,
  input wire logic exit_req,
  input wire logic exit_ext_intr,
  input wire logic intr_vec_valid,
  input wire logic [7:0] intr_vec,
  input wire logic func_req,
  input wire logic [31:0] func_leaf,
  input wire logic [8:0] func_index,
  output logic [15:0] tag_q,
  output logic pause_exit_q,
  output logic entry_ok_q,
  output logic entry_fail_q,
  output logic intr_ack_q,
  output logic exit_done_q,
  output logic save_debug_q,
  output logic load_perf_q,
  output logic save_pat_q,
  output logic load_pat_q,
  output logic save_efer_q,
  output logic load_efer_q,
  output logic save_timer_q,
  output logic cs_long_q,
  output logic long_mode_enable_bit_q,
  output logic long_mode_active_bit_q,
  output logic info_valid_q,
  output logic [7:0] info_vector_q,
  output logic switch_go_q,
  output logic [63:0] switch_entry_addr_q,
  output logic func_fail_q
);

  // Exit bits forced by the build: debug save in minimal form.
  localparam logic [31:0] MUST1 = `VXEC_EXIT_MUST1 |
    (MINIMAL ? (32'h0000_0001 << `VXEC_EXIT_SAVE_DBG) : 32'h0000_0000);
  // Host long mode is illegal without long-mode support.
  localparam logic [31:0] MUST0 = `VXEC_EXIT_MUST0 |
    (HAS_LONG ? 32'h0000_0000 : (32'h0000_0001 << `VXEC_EXIT_HOST_LONG));

  // Stored fields.
  logic [31:0] gap_q;
  logic [31:0] win_q;
  logic func_switch_q;
  logic func_rsvd_q;
  logic [63:0] list_q;
  logic [31:0] exit_q;
  // Last pause exit seen, for the status word.
  logic pause_flag_q;
  // Exit sequencer state.
  vxec_exit_state_type state_q;
  // Timestamp-rate divider.
  logic [15:0] div_q;
  logic tsc_tick_q;
  // Pause timer exit pulse.
  logic loop_exit;

  // True when the byte offset names a given register.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // A write strobe aimed at one register.
  function automatic logic wr_at(input logic [7:0] off);
    return reg_wr && hit(reg_addr, off);
  endfunction

  // Reserved exit bits set wrongly.
  function automatic logic exit_bad(input logic [31:0] v);
    return ((v & MUST0) != 32'h0000_0000) || ((~v & MUST1) != 32'h0000_0000);
  endfunction

  // tick divider
  // One enable pulse per timestamp tick drives all pause timing.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 16'h0000;
      tsc_tick_q <= 1'b0;
    end else if (div_q == 16'(TSC_DIV - 1)) begin
      div_q <= 16'h0000;
      tsc_tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tsc_tick_q <= 1'b0;
    end
  end

  // tag field
  // The tag only stores when the build supports it.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tag_q <= `VXEC_RST_TAG;
    end else if (HAS_TAG && wr_at(`VXEC_OFF_TAG)) begin
      tag_q <= reg_wdata[15:0];
    end
  end

  // window field
  // Pause limits hold until software rewrites them.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= `VXEC_RST_WORD;
      win_q <= `VXEC_RST_WORD;
    end else if (HAS_PAUSE) begin
      if (wr_at(`VXEC_OFF_GAP)) begin
        gap_q <= reg_wdata;
      end
      if (wr_at(`VXEC_OFF_WIN)) begin
        win_q <= reg_wdata;
      end
    end
  end

  // reserved bits zero
  // Only the switch bit is stored; a nonzero reserved write is
  // remembered separately so the next entry can fail.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      func_switch_q <= 1'b0;
      func_rsvd_q <= 1'b0;
    end else if (HAS_FUNC) begin
      if (wr_at(`VXEC_OFF_FUNC_LO)) begin
        func_switch_q <= reg_wdata[`VXEC_FUNC_SWITCH_BIT] && HAS_SWITCH;
        func_rsvd_q <= (reg_wdata[31:1] != 31'h0000_0000) || !HAS_SWITCH
          && reg_wdata[0];
      end else if (wr_at(`VXEC_OFF_FUNC_HI)) begin
        func_rsvd_q <= func_rsvd_q || (reg_wdata != 32'h0000_0000);
      end
    end
  end

  // list base
  // The list base is written as two halves.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      list_q <= {`VXEC_RST_WORD, `VXEC_RST_WORD};
    end else if (HAS_SWITCH) begin
      if (wr_at(`VXEC_OFF_LIST_LO)) begin
        list_q[31:0] <= reg_wdata;
      end
      if (wr_at(`VXEC_OFF_LIST_HI)) begin
        list_q[63:32] <= reg_wdata;
      end
    end
  end

  // exit vector
  // The whole word is kept as written so a bad setting can be seen.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      exit_q <= `VXEC_RST_WORD;
    end else if (wr_at(`VXEC_OFF_EXIT)) begin
      exit_q <= reg_wdata;
    end
  end

  // reserved exit bits
  // Each entry request yields exactly one of ok or fail next cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      entry_ok_q <= 1'b0;
      entry_fail_q <= 1'b0;
    end else if (entry_req) begin
      entry_fail_q <= func_rsvd_q || exit_bad(exit_q);
      entry_ok_q <= !(func_rsvd_q || exit_bad(exit_q));
    end
  end

  // pause timer
  // The detector is fed the timestamp tick, never the core clock.
  vxec_pause_timer #(
    .W(32)
  ) u_pause (
    .clock(clock),
    .arst_n(arst_n),
    .enable(pause_enable && HAS_PAUSE),
    .tick(tsc_tick_q),
    .pause_seen(pause_exec),
    .gap_limit(gap_q),
    .window_limit(win_q),
    .loop_exit_q(loop_exit)
  );

  // Register the pause exit and keep a sticky copy; a new exit wins
  // over the clearing read of the status word.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pause_exit_q <= 1'b0;
      pause_flag_q <= 1'b0;
    end else begin
      pause_exit_q <= loop_exit;
      if (loop_exit) begin
        pause_flag_q <= 1'b1;
      end else if (reg_rd && hit(reg_addr, `VXEC_OFF_STATUS)) begin
        pause_flag_q <= 1'b0;
      end
    end
  end

  // pointer switching
  // Leaf zero with the switch bit set picks one list entry.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      switch_go_q <= 1'b0;
      func_fail_q <= 1'b0;
      switch_entry_addr_q <= 64'h0000_0000_0000_0000;
    end else begin
      switch_go_q <= 1'b0;
      func_fail_q <= 1'b0;
      if (func_req) begin
        if (func_leaf == 32'h0000_0000 && func_switch_q) begin
          switch_go_q <= 1'b1;
          switch_entry_addr_q <= list_q +
            (64'(func_index) << `VXEC_LIST_ENTRY_SHIFT);
        end else begin
          func_fail_q <= 1'b1;
        end
      end
    end
  end

  // Exit sequencer: idle, waiting for the vector, finishing.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= VXEC_IDLE;
    end else begin
      unique case (state_q)
        VXEC_IDLE: begin
          if (exit_req && exit_ext_intr
              && exit_q[`VXEC_EXIT_ACK_INTR]) begin
            state_q <= VXEC_ACK_WAIT;
          end else if (exit_req) begin
            state_q <= VXEC_FINISH;
          end
        end
        VXEC_ACK_WAIT: begin
          if (intr_vec_valid) begin
            state_q <= VXEC_FINISH;
          end
        end
        VXEC_FINISH: begin
          state_q <= VXEC_IDLE;
        end
        default: begin
          state_q <= VXEC_IDLE;
        end
      endcase
    end
  end

  // acknowledge pulse
  // One acknowledge pulse as the sequencer leaves idle for the vector wait.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      intr_ack_q <= 1'b0;
    end else begin
      intr_ack_q <= (state_q == VXEC_IDLE) && exit_req && exit_ext_intr
        && exit_q[`VXEC_EXIT_ACK_INTR];
    end
  end

  // Interruption information for the exit being taken.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      info_valid_q <= 1'b0;
      info_vector_q <= 8'h00;
    end else if (state_q == VXEC_ACK_WAIT && intr_vec_valid) begin
      info_valid_q <= 1'b1;
      info_vector_q <= intr_vec;
    end else if (state_q == VXEC_IDLE && exit_req
                 && !(exit_ext_intr && exit_q[`VXEC_EXIT_ACK_INTR])) begin
      info_valid_q <= 1'b0;
    end
  end

  // Exit actions: all selections appear with the done pulse.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      exit_done_q <= 1'b0;
      save_debug_q <= 1'b0;
      load_perf_q <= 1'b0;
      save_pat_q <= 1'b0;
      load_pat_q <= 1'b0;
      save_efer_q <= 1'b0;
      load_efer_q <= 1'b0;
      save_timer_q <= 1'b0;
    end else begin
      exit_done_q <= state_q == VXEC_FINISH;
      if (state_q == VXEC_FINISH) begin
        save_debug_q <= exit_q[`VXEC_EXIT_SAVE_DBG] || MINIMAL;
        load_perf_q <= exit_q[`VXEC_EXIT_LOAD_PERF];
        save_pat_q <= exit_q[`VXEC_EXIT_SAVE_PAT];
        load_pat_q <= exit_q[`VXEC_EXIT_LOAD_PAT];
        save_efer_q <= exit_q[`VXEC_EXIT_SAVE_EFER];
        load_efer_q <= exit_q[`VXEC_EXIT_LOAD_EFER];
        save_timer_q <= exit_q[`VXEC_EXIT_SAVE_TMR];
      end
    end
  end

  // gated without support
  // Every exit copies the host size bit into all three mode bits.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_long_q <= 1'b0;
      long_mode_enable_bit_q <= 1'b0;
      long_mode_active_bit_q <= 1'b0;
    end else if (state_q == VXEC_FINISH) begin
      cs_long_q <= exit_q[`VXEC_EXIT_HOST_LONG] && HAS_LONG;
      long_mode_enable_bit_q <= exit_q[`VXEC_EXIT_HOST_LONG] && HAS_LONG;
      long_mode_active_bit_q <= exit_q[`VXEC_EXIT_HOST_LONG] && HAS_LONG;
    end
  end

  // read back
  // Read data stand for the one cycle after the strobe, else zero.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        `VXEC_OFF_TAG: reg_rdata <= {16'h0000, tag_q};
        `VXEC_OFF_GAP: reg_rdata <= gap_q;
        `VXEC_OFF_WIN: reg_rdata <= win_q;
        `VXEC_OFF_FUNC_LO: reg_rdata <= {31'h0000_0000, func_switch_q};
        `VXEC_OFF_FUNC_HI: reg_rdata <= 32'h0000_0000;
        `VXEC_OFF_LIST_LO: reg_rdata <= list_q[31:0];
        `VXEC_OFF_LIST_HI: reg_rdata <= list_q[63:32];
        `VXEC_OFF_EXIT: reg_rdata <= exit_q;
        `VXEC_OFF_STATUS: begin
          reg_rdata <= {27'h000_0000, pause_flag_q, state_q != VXEC_IDLE,
            func_rsvd_q, entry_fail_q, entry_ok_q};
        end
        `VXEC_OFF_INFO: begin
          reg_rdata <= {info_valid_q, 23'h00_0000, info_vector_q};
        end
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // vxec_top
`default_nettype wire

// >>> vxec_top_properties.sv
// Purpose: Port-level timing checks for the vxec control block.
// Assumes: One clock domain; exit_req is only raised while idle.
// Notes: Bound to every vxec_top instance after the module.
`timescale 1ns/1ps
`default_nettype none
module vxec_top_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pause_exec,
  input wire logic pause_enable,
  input wire logic entry_req,
  input wire logic exit_req,
  input wire logic exit_ext_intr,
  input wire logic intr_vec_valid,
  input wire logic [7:0] intr_vec,
  input wire logic func_req,
  input wire logic [31:0] func_leaf,
  input wire logic pause_exit_q,
  input wire logic entry_ok_q,
  input wire logic entry_fail_q,
  input wire logic intr_ack_q,
  input wire logic exit_done_q,
  input wire logic save_debug_q,
  input wire logic load_perf_q,
  input wire logic save_pat_q,
  input wire logic load_pat_q,
  input wire logic save_efer_q,
  input wire logic load_efer_q,
  input wire logic save_timer_q,
  input wire logic cs_long_q,
  input wire logic long_mode_enable_bit_q,
  input wire logic long_mode_active_bit_q,
  input wire logic info_valid_q,
  input wire logic [7:0] info_vector_q,
  input wire logic switch_go_q,
  input wire logic func_fail_q
);
  // All checks share the core clock and are off while reset is low.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_read_data_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_entry_one_verdict: assert property (
    entry_req |=> entry_ok_q ^ entry_fail_q)
    else $error("entry check gave no single verdict");
  a_entry_verdict_held: assert property (
    !$past(entry_req) |-> $stable({entry_ok_q, entry_fail_q}))
    else $error("entry verdict changed without a request");
  a_exit_no_ack: assert property (
    exit_req && !exit_ext_intr |=> !intr_ack_q ##1 exit_done_q)
    else $error("plain exit acknowledged or late");
  a_ack_stores_vector: assert property (
    intr_vec_valid |=> info_valid_q && info_vector_q == $past(intr_vec)
    ##1 exit_done_q)
    else $error("fetched vector not stored or exit not done");
  a_ack_single_pulse: assert property (intr_ack_q |=> !intr_ack_q)
    else $error("acknowledge longer than one cycle");
  a_done_single_pulse: assert property (exit_done_q |=> !exit_done_q)
    else $error("exit done longer than one cycle");
  a_long_bits_equal: assert property (
    cs_long_q == long_mode_enable_bit_q
    && long_mode_active_bit_q == cs_long_q)
    else $error("long-mode bits disagree");
  a_actions_at_exit: assert property (
    $changed({save_debug_q, load_perf_q, save_pat_q, load_pat_q,
    save_efer_q, load_efer_q, save_timer_q, cs_long_q}) |-> exit_done_q)
    else $error("exit actions changed outside an exit");
  a_func_bad_leaf: assert property (
    func_req && func_leaf != 32'h0000_0000 |=> func_fail_q && !switch_go_q)
    else $error("unknown function leaf not refused");
  a_pause_exit_cause: assert property (
    pause_exit_q |-> $past(pause_exec, 2) && pause_enable)
    else $error("pause exit without a pause two cycles before");
endmodule // vxec_top_props

bind vxec_top vxec_top_props i_vxec_top_props (.clock(clock), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pause_exec(pause_exec),
  .pause_enable(pause_enable), .entry_req(entry_req), .exit_req(exit_req),
  .exit_ext_intr(exit_ext_intr), .intr_vec_valid(intr_vec_valid),
  .intr_vec(intr_vec), .func_req(func_req), .func_leaf(func_leaf),
  .pause_exit_q(pause_exit_q), .entry_ok_q(entry_ok_q),
  .entry_fail_q(entry_fail_q), .intr_ack_q(intr_ack_q),
  .exit_done_q(exit_done_q), .save_debug_q(save_debug_q),
  .load_perf_q(load_perf_q), .save_pat_q(save_pat_q),
  .load_pat_q(load_pat_q), .save_efer_q(save_efer_q),
  .load_efer_q(load_efer_q), .save_timer_q(save_timer_q),
  .cs_long_q(cs_long_q), .long_mode_enable_bit_q(long_mode_enable_bit_q),
  .long_mode_active_bit_q(long_mode_active_bit_q),
  .info_valid_q(info_valid_q), .info_vector_q(info_vector_q),
  .switch_go_q(switch_go_q), .func_fail_q(func_fail_q));
`default_nettype wire

// >>> vxec_top_tb.sv
// Purpose: Self-checking bench for the vxec control block.
// Assumes: TSC_DIV set to 2 to keep pause loops short.
// Notes: Register rows first, then hand-written entry, exit, function, pause cases.
`timescale 1ns/1ps
`default_nettype none
`include "vxec_consts.svh"
module vxec_top_tb;
  logic clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic pause_exec = 1'b0, pause_enable = 1'b0, entry_req = 1'b0;
  logic exit_req = 1'b0, exit_ext_intr = 1'b0, intr_vec_valid = 1'b0;
  logic func_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, intr_vec = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, func_leaf = 32'h0000_0000;
  logic [8:0] func_index = 9'h000;
  logic [31:0] reg_rdata, v;
  logic [15:0] tag_q;
  logic pause_exit_q, entry_ok_q, entry_fail_q, intr_ack_q, exit_done_q;
  logic save_debug_q, load_perf_q, save_pat_q, load_pat_q, save_efer_q;
  logic load_efer_q, save_timer_q, cs_long_q, long_mode_enable_bit_q;
  logic long_mode_active_bit_q, info_valid_q, switch_go_q, func_fail_q;
  logic [7:0] info_vector_q;
  logic [63:0] switch_entry_addr_q;
  // Exit action and mode outputs gathered into one word for comparison.
  logic [9:0] acts;
  assign acts = {save_debug_q, load_perf_q, save_pat_q, load_pat_q,
    save_efer_q, load_efer_q, save_timer_q, cs_long_q,
    long_mode_enable_bit_q, long_mode_active_bit_q};
  int n_errors = 0, compares = 0, cycles = 0, n_pause = 0, i;
  // Register rows: address, written word, expected read-back.
  logic [7:0] ra [10] = '{`VXEC_OFF_TAG, `VXEC_OFF_GAP, `VXEC_OFF_WIN,
    `VXEC_OFF_FUNC_HI, `VXEC_OFF_FUNC_LO, `VXEC_OFF_FUNC_LO,
    `VXEC_OFF_LIST_LO, `VXEC_OFF_LIST_HI, `VXEC_OFF_EXIT, 8'h30};
  logic [31:0] rw [10] = '{32'hFFFF_ABCD, 32'h0000_0064, 32'h0000_0004,
    32'h0000_0002, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_1000,
    32'h0000_0001, 32'h007F_FFFF, 32'hDEAD_BEEF};
  logic [31:0] rx [10] = '{32'h0000_ABCD, 32'h0000_0064, 32'h0000_0004,
    32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_1000,
    32'h0000_0001, 32'h007F_FFFF, 32'h0000_0000};
  // Exit words for the entry check and whether each should pass.
  logic [31:0] ev [4] = '{32'h007F_FFFF, 32'h00FF_FFFF, 32'h007F_FFFE,
    32'h007F_FDFF};
  logic [1:0] ee [4] = '{2'h2, 2'h1, 2'h1, 2'h2};

  vxec_top #(.TSC_DIV(2)) i_vxec_top (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pause_exec(pause_exec),
    .pause_enable(pause_enable), .entry_req(entry_req), .exit_req(exit_req),
    .exit_ext_intr(exit_ext_intr), .intr_vec_valid(intr_vec_valid),
    .intr_vec(intr_vec), .func_req(func_req), .func_leaf(func_leaf),
    .func_index(func_index), .tag_q(tag_q), .pause_exit_q(pause_exit_q),
    .entry_ok_q(entry_ok_q), .entry_fail_q(entry_fail_q),
    .intr_ack_q(intr_ack_q), .exit_done_q(exit_done_q),
    .save_debug_q(save_debug_q), .load_perf_q(load_perf_q),
    .save_pat_q(save_pat_q), .load_pat_q(load_pat_q),
    .save_efer_q(save_efer_q), .load_efer_q(load_efer_q),
    .save_timer_q(save_timer_q), .cs_long_q(cs_long_q),
    .long_mode_enable_bit_q(long_mode_enable_bit_q),
    .long_mode_active_bit_q(long_mode_active_bit_q),
    .info_valid_q(info_valid_q), .info_vector_q(info_vector_q),
    .switch_go_q(switch_go_q), .switch_entry_addr_q(switch_entry_addr_q),
    .func_fail_q(func_fail_q));

  // Clock of 5 ns period.
  always #2.5 clock = ~clock;

  // Counts pause exit pulses and cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (pause_exit_q === 1'b1) n_pause++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // Compares one result of up to 64 bits.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; data taken in the answer cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Entry check request; verdict seen one cycle later.
  task automatic entry(input logic [1:0] e);
    @(posedge clock);
    entry_req <= 1'b1;
    @(posedge clock);
    entry_req <= 1'b0;
    #1 chk({entry_ok_q, entry_fail_q}, e);
  endtask

  // Guest function request with leaf and index.
  task automatic func(input logic [31:0] l, input logic [8:0] x);
    @(posedge clock);
    func_req <= 1'b1;
    func_leaf <= l;
    func_index <= x;
    @(posedge clock);
    func_req <= 1'b0;
    #1;
  endtask

  // Exit request, x marking an external interrupt; an acknowledge is
  // answered with vector 8'hA5.
  task automatic do_exit(input logic ack, input logic x);
    @(posedge clock);
    exit_req <= 1'b1;
    exit_ext_intr <= x;
    @(posedge clock);
    exit_req <= 1'b0;
    #1 chk(intr_ack_q, ack);
    if (ack) begin
      @(posedge clock);
      intr_vec_valid <= 1'b1;
      intr_vec <= 8'hA5;
      @(posedge clock);
      intr_vec_valid <= 1'b0;
    end
    for (i = 0; i < 8 && exit_done_q !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk(exit_done_q, 1'b1);
  endtask

  // Guest pauses at a fixed spacing.
  task automatic pauses(input int n, input int gap);
    repeat (n) begin
      @(posedge clock);
      pause_exec <= 1'b1;
      @(posedge clock);
      pause_exec <= 1'b0;
      repeat (gap) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask

  // Holds reset low for 16 cycles.
  task automatic do_reset();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk({tag_q, entry_ok_q, intr_ack_q, cs_long_q, info_valid_q}, 0);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    do_reset();
    for (i = 0; i < 10; i++) begin
      rd(ra[i], v);
      chk(v, 32'h0000_0000);
    end
    $display("test reset values done");
    for (int r = 0; r < 10; r++) begin
      wr(ra[r], rw[r]);
      rd(ra[r], v);
      chk(v, rx[r]);
    end
    chk(tag_q, 16'hABCD);
    $display("test register rows done");
    entry(2'h2);
    wr(`VXEC_OFF_FUNC_HI, 32'h0000_0001);
    entry(2'h1);
    rd(`VXEC_OFF_STATUS, v);
    chk(v, 32'h0000_0006);
    wr(`VXEC_OFF_FUNC_LO, 32'h0000_0001);
    for (int r = 0; r < 4; r++) begin
      wr(`VXEC_OFF_EXIT, ev[r]);
      entry(ee[r]);
    end
    $display("test entry checks done");
    wr(`VXEC_OFF_EXIT, 32'h007F_FFFF);
    do_exit(1'b1, 1'b1);
    chk(acts, 10'h3FF);
    chk({info_valid_q, info_vector_q}, 9'h1A5);
    rd(`VXEC_OFF_INFO, v);
    chk(v, 32'h8000_00A5);
    wr(`VXEC_OFF_EXIT, 32'h007F_7DFF);
    do_exit(1'b0, 1'b1);
    chk(acts, 10'h3F8);
    chk(info_valid_q, 1'b0);
    // A plain exit with only the forced-one bits set clears every option except the debug save.
    wr(`VXEC_OFF_EXIT, `VXEC_EXIT_MUST1);
    do_exit(1'b0, 1'b0);
    chk(acts, 10'h200);
    $display("test exits done");
    func(32'h0000_0000, 9'h1FF);
    chk({switch_go_q, func_fail_q}, 2'h2);
    chk(switch_entry_addr_q, 64'h0000_0001_0000_1FF8);
    func(32'h0000_0001, 9'h000);
    chk({switch_go_q, func_fail_q}, 2'h1);
    wr(`VXEC_OFF_FUNC_LO, 32'h0000_0000);
    func(32'h0000_0000, 9'h001);
    chk({switch_go_q, func_fail_q}, 2'h1);
    $display("test functions done");
    @(posedge clock);
    pause_enable <= 1'b1;
    n_pause = 0;
    pauses(40, 2);
    chk(n_pause != 0, 1'b1);
    rd(`VXEC_OFF_STATUS, v);
    chk(v[4], 1'b1);
    rd(`VXEC_OFF_STATUS, v);
    chk(v[4], 1'b0);
    wr(`VXEC_OFF_GAP, 32'h0000_0001);
    n_pause = 0;
    pauses(20, 18);
    chk(n_pause, 0);
    $display("test pause loops done");
    do_reset();
    rd(`VXEC_OFF_TAG, v);
    chk(v, 32'h0000_0000);
    $display("test second reset done");
    final_report();
  end
endmodule // vxec_top_tb
`default_nettype wire
